// ===== hw/css_pkg.sv
// Constants and state type of the coding sublayer status register bank.
// Assumes one clock domain and an APB master with 32-bit data.
`default_nettype none

package css_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indexes as printed, with the space prefix in bits 15:12
  localparam logic [15:0] STATUS_IDX_PRINTED = 16'h38E7;
  localparam logic [15:0] CONTROL_IDX_PRINTED = 16'h3000;
  localparam logic [3:0] SPACE_PREFIX = 4'h3;
  localparam int PREFIX_LSB = 12;

  // Prefix stripped, as software addresses the space
  function automatic logic [15:0] strip_prefix(input logic [15:0] printed);
    strip_prefix = {4'h0, printed[PREFIX_LSB-1:0]};
  endfunction

  localparam logic [15:0] STATUS_IDX = strip_prefix(STATUS_IDX_PRINTED);
  localparam logic [15:0] CONTROL_IDX = strip_prefix(CONTROL_IDX_PRINTED);
  localparam logic [15:0] IRQ_STATUS_IDX = 16'h0F00;
  localparam logic [15:0] IRQ_MASK_IDX = 16'h0F01;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int REG_W = 16;
  localparam int ST_TX_LPI_SEEN = 11;
  localparam int ST_RX_LPI_SEEN = 10;
  localparam int ST_TX_LPI_LIVE = 9;
  localparam int ST_RX_LPI_LIVE = 8;
  localparam int ST_FAULT = 7;
  localparam int ST_LINK = 2;
  localparam int CT_SOFT_RESET = 15;
  localparam int CT_LOOPBACK = 14;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  localparam int IRQ_W = 4;
  localparam int IRQ_TX_LPI = 0;
  localparam int IRQ_RX_LPI = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_LINK_DOWN = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Whole module state, registered in one process
  typedef struct packed {
    logic [1:0] tx_sync;
    logic [1:0] rx_sync;
    logic [1:0] fault_sync;
    logic [1:0] link_sync;
    logic tx_prev;
    logic rx_prev;
    logic fault_prev;
    logic link_prev;
    logic tx_seen;
    logic rx_seen;
    logic fault_seen;
    logic link_latch;
    logic loopback;
    logic soft_reset;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } css_state_t;

endpackage

`default_nettype wire

// ===== hw/css_status_regs.sv
// Coding sublayer status and control registers behind an APB slave.
// Assumes sublayer indications arrive asynchronously; all are synchronised.
//
// The APB register port was left to the implementer.
`default_nettype none

// Contract
// - Status register sits at printed index 0x38E7 and resets to zero.
// - Bit 11 latches once transmit side has seen low-power idle.
// - Bit 10 latches once receive side has seen low-power idle.
// - Bit 9 shows live transmit low-power idle, read-only.
// - Bit 8 shows live receive low-power idle, read-only.
// - Bit 7 latches a detected fault, cleared by software.
// - Bit 2 shows receive link up, latch-low, resets to zero.
// - Control register gives self-clearing soft reset and loopback enable.
module css_status_regs
  import css_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sublayer indications
  input wire logic tx_lpi_active,
  input wire logic rx_lpi_active,
  input wire logic fault_detect,
  input wire logic rx_link_up,
  // Sublayer controls and interrupt
  output logic sublayer_soft_reset,
  output logic sublayer_loopback_enable,
  output logic irq
);

  css_state_t st_r;
  css_state_t st_nxt;
  logic setup;
  logic done;
  logic wr;
  logic rd;
  logic [15:0] idx;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = 16'(a >> 2);
  endfunction

  function automatic logic is_mapped(input logic [15:0] i);
    is_mapped = (i == STATUS_IDX) || (i == CONTROL_IDX) ||
                (i == IRQ_STATUS_IDX) || (i == IRQ_MASK_IDX);
  endfunction

  // Byte lane enable of a bit position
  function automatic logic lane_on(input logic [3:0] strb, input int bitpos);
    lane_on = strb[bitpos / 8];
  endfunction

  function automatic logic [31:0] read_word(input css_state_t s,
                                            input logic [15:0] i);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (i)
      STATUS_IDX:
      begin
        w[ST_TX_LPI_SEEN] = s.tx_seen;
        w[ST_RX_LPI_SEEN] = s.rx_seen;
        w[ST_TX_LPI_LIVE] = s.tx_sync[1];
        w[ST_RX_LPI_LIVE] = s.rx_sync[1];
        w[ST_FAULT] = s.fault_seen;
        w[ST_LINK] = s.link_latch;
      end
      CONTROL_IDX:
      begin
        w[CT_SOFT_RESET] = s.soft_reset;
        w[CT_LOOPBACK] = s.loopback;
      end
      IRQ_STATUS_IDX: w[IRQ_W-1:0] = s.irq_status;
      IRQ_MASK_IDX: w[IRQ_W-1:0] = s.irq_mask;
      default: w = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  assign idx = word_index(paddr);
  assign setup = psel && !penable;
  assign done = psel && penable && st_r.pready;
  assign wr = done && pwrite;
  assign rd = done && !pwrite;

  always_comb
  begin
    st_nxt = st_r;
    // Two-stage synchronisers; logic reads only the second stage
    st_nxt.tx_sync = {st_r.tx_sync[0], tx_lpi_active};
    st_nxt.rx_sync = {st_r.rx_sync[0], rx_lpi_active};
    st_nxt.fault_sync = {st_r.fault_sync[0], fault_detect};
    st_nxt.link_sync = {st_r.link_sync[0], rx_link_up};
    st_nxt.tx_prev = st_r.tx_sync[1];
    st_nxt.rx_prev = st_r.rx_sync[1];
    st_nxt.fault_prev = st_r.fault_sync[1];
    st_nxt.link_prev = st_r.link_sync[1];

    // Zero-wait APB: answer in the first access cycle
    st_nxt.pready = setup;
    st_nxt.pslverr = setup && !is_mapped(idx);
    st_nxt.prdata = (setup && !pwrite) ? read_word(st_r, idx) : 32'h0000_0000;

    // Self-clearing: soft reset lives one cycle
    // soft reset pulse
    st_nxt.soft_reset = 1'b0;

    // Clears first, so that a same-cycle event below wins
    if (st_r.soft_reset)
    begin
      st_nxt.tx_seen = 1'b0;
      st_nxt.rx_seen = 1'b0;
      st_nxt.fault_seen = 1'b0;
      st_nxt.link_latch = st_r.link_sync[1];
    end

    if (wr && idx == STATUS_IDX)
    begin
      if (lane_on(pstrb, ST_TX_LPI_SEEN) && !pwdata[ST_TX_LPI_SEEN])
        st_nxt.tx_seen = 1'b0;
      if (lane_on(pstrb, ST_RX_LPI_SEEN) && !pwdata[ST_RX_LPI_SEEN])
        st_nxt.rx_seen = 1'b0;
      if (lane_on(pstrb, ST_FAULT) && !pwdata[ST_FAULT])
        st_nxt.fault_seen = 1'b0;
      if (lane_on(pstrb, ST_LINK) && !pwdata[ST_LINK])
        st_nxt.link_latch = st_r.link_sync[1];
    end

    if (rd && idx == STATUS_IDX)
      st_nxt.link_latch = st_r.link_sync[1];

    if (wr && idx == CONTROL_IDX && lane_on(pstrb, CT_SOFT_RESET))
    begin
      st_nxt.soft_reset = pwdata[CT_SOFT_RESET];
      st_nxt.loopback = pwdata[CT_LOOPBACK];
    end

    if (wr && idx == IRQ_STATUS_IDX && pstrb[0])
      st_nxt.irq_status = st_r.irq_status & ~pwdata[IRQ_W-1:0];
    if (wr && idx == IRQ_MASK_IDX && pstrb[0])
      st_nxt.irq_mask = pwdata[IRQ_W-1:0];

    // Events last: set beats any clear in the same cycle
    // latch transmit idle
    if (st_r.tx_sync[1])
      st_nxt.tx_seen = 1'b1;
    if (st_r.rx_sync[1])
      st_nxt.rx_seen = 1'b1;
    if (st_r.fault_sync[1])
      st_nxt.fault_seen = 1'b1;
    if (!st_r.link_sync[1])
      st_nxt.link_latch = 1'b0;

    if (st_r.tx_sync[1] && !st_r.tx_prev)
      st_nxt.irq_status[IRQ_TX_LPI] = 1'b1;
    if (st_r.rx_sync[1] && !st_r.rx_prev)
      st_nxt.irq_status[IRQ_RX_LPI] = 1'b1;
    if (st_r.fault_sync[1] && !st_r.fault_prev)
      st_nxt.irq_status[IRQ_FAULT] = 1'b1;
    if (!st_r.link_sync[1] && st_r.link_prev)
      st_nxt.irq_status[IRQ_LINK_DOWN] = 1'b1;

    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.irq_status <= IRQ_RESET;
      st_r.irq_mask <= IRQ_RESET;
      st_r.loopback <= CONTROL_RESET[CT_LOOPBACK];
      st_r.soft_reset <= CONTROL_RESET[CT_SOFT_RESET];
      st_r.link_latch <= STATUS_RESET[ST_LINK];
    end
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign sublayer_soft_reset = st_r.soft_reset;
  assign sublayer_loopback_enable = st_r.loopback;
  assign irq = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_status_read;
    psel && !penable && !pwrite && idx == STATUS_IDX;
  endsequence

  sequence s_status_clear_all;
    wr && idx == STATUS_IDX && pstrb[1:0] == 2'b11 && pwdata[15:0] == 16'h0000;
  endsequence

  property p_status_mapped;
    @(posedge pclk) disable iff (!presetn)
    s_status_read |=> pready && !pslverr && prdata[31:REG_W] == 16'h0000;
  endproperty
  a_status_mapped: assert property (p_status_mapped)
    else $error("status read answered wrongly");

  property p_tx_seen;
    @(posedge pclk) disable iff (!presetn)
    st_r.tx_sync[1] |=> st_r.tx_seen;
  endproperty
  a_tx_seen: assert property (p_tx_seen)
    else $error("transmit idle not latched");

  property p_rx_seen;
    @(posedge pclk) disable iff (!presetn)
    $rose(st_r.rx_sync[1]) |=> st_r.rx_seen ##1 st_r.rx_seen;
  endproperty
  a_rx_seen: assert property (p_rx_seen)
    else $error("receive idle not latched");

  property p_tx_live;
    @(posedge pclk) disable iff (!presetn)
    s_status_read |=> prdata[ST_TX_LPI_LIVE] == $past(st_r.tx_sync[1]);
  endproperty
  a_tx_live: assert property (p_tx_live)
    else $error("transmit live bit wrong");

  property p_rx_live;
    @(posedge pclk) disable iff (!presetn)
    s_status_read |=> prdata[ST_RX_LPI_LIVE] == $past(st_r.rx_sync[1]);
  endproperty
  a_rx_live: assert property (p_rx_live)
    else $error("receive live bit wrong");

  property p_fault;
    @(posedge pclk) disable iff (!presetn)
    st_r.fault_sync[1] ##0 s_status_clear_all |=> st_r.fault_seen;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault clear beat a new fault");

  property p_link_low;
    @(posedge pclk) disable iff (!presetn)
    !st_r.link_sync[1] |=> !st_r.link_latch;
  endproperty
  a_link_low: assert property (p_link_low)
    else $error("link flag not low after loss");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    st_r.tx_seen && !(wr && idx == STATUS_IDX) && !st_r.soft_reset
      |=> st_r.tx_seen;
  endproperty
  a_hold: assert property (p_hold)
    else $error("latched flag dropped by itself");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    s_status_read |=> (prdata & 32'h0000_F07B) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits not zero");

  property p_soft_reset;
    @(posedge pclk) disable iff (!presetn)
    sublayer_soft_reset && !st_r.fault_sync[1]
      |=> !sublayer_soft_reset && !st_r.fault_seen;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not self clear");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    setup && !is_mapped(idx)
      |=> pready && pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped index not refused");

  property p_link_rearm;
    @(posedge pclk) disable iff (!presetn)
    rd && idx == STATUS_IDX && st_r.link_sync[1] |=> st_r.link_latch;
  endproperty
  a_link_rearm: assert property (p_link_rearm)
    else $error("status read did not re-arm link flag");

  property p_ctrl_lane;
    @(posedge pclk) disable iff (!presetn)
    wr && idx == CONTROL_IDX && !pstrb[1]
      |=> $stable(sublayer_loopback_enable) && !sublayer_soft_reset;
  endproperty
  a_ctrl_lane: assert property (p_ctrl_lane)
    else $error("control changed with its lane off");

  property p_irq_set_wins;
    @(posedge pclk) disable iff (!presetn)
    st_r.fault_sync[1] && !st_r.fault_prev |=> st_r.irq_status[IRQ_FAULT];
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins)
    else $error("fault event lost from interrupt status");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    irq == |(st_r.irq_status & st_r.irq_mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output inconsistent");

endmodule

`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the coding sublayer status register bank.
// Assumes the zero-wait APB slave and 2-flop input synchronisers.
`default_nettype none

module tb_top
  import css_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Byte addresses: index times four, prefix stripped except in A_PR
  localparam logic [15:0] A_ST = {STATUS_IDX[13:0], 2'b00};
  localparam logic [15:0] A_CT = {CONTROL_IDX[13:0], 2'b00};
  localparam logic [15:0] A_IS = {IRQ_STATUS_IDX[13:0], 2'b00};
  localparam logic [15:0] A_IM = {IRQ_MASK_IDX[13:0], 2'b00};
  localparam logic [15:0] A_PR = {STATUS_IDX_PRINTED[13:0], 2'b00};
  localparam logic [15:0] A_BAD = 16'h1000;

  logic pclk;
  logic presetn;
  logic [15:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] ind;
  logic soft_rst;
  logic loop_en;
  logic irq;
  int err_total;
  int cmp_count;
  logic [31:0] rnd;
  logic [31:0] d;
  logic e;
  logic [2:0] seen;
  logic [3:0] mask;
  int cnt;

  css_status_regs css_status_regs_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_lpi_active(ind[0]), .rx_lpi_active(ind[1]),
    .fault_detect(ind[2]), .rx_link_up(ind[3]),
    .sublayer_soft_reset(soft_rst), .sublayer_loopback_enable(loop_en),
    .irq(irq)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [31:0] exp_st(input logic [2:0] sn,
    input logic [1:0] lv, input logic lk);
    return {20'h00000, sn[2:1], lv, sn[0], 4'h0, lk, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    cmp_count++;
    if (seen_v !== exp_v)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic x;
    apb(1'b1, a, wd, r, x);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic x;
    apb(1'b0, a, 32'h0, r, x);
    chk(r, ex);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    wrap_up();
  end

  initial
  begin
    err_total = 0;
    cmp_count = 0;
    // Seed 56719
    rnd = 32'h0000DD8F;
    presetn = 1'b0;
    paddr = 16'h0000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    ind = 4'h0;
    wt(3);
    presetn <= 1'b1;
    rdc(A_ST, {16'h0000, STATUS_RESET});
    rdc(A_CT, {16'h0000, CONTROL_RESET});
    rdc(A_IS, 32'h0);
    rdc(A_IM, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Unmapped places, including the unstripped printed index
    apb(1'b0, A_BAD, 32'h0, d, e);
    chk(d, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(A_PR, 32'h0000FFFF);
    apb(1'b0, A_PR, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    rdc(A_ST, 32'h0);
    // Link latches low until read
    ind[3] <= 1'b1;
    wt(4);
    rdc(A_ST, exp_st(3'b000, 2'b00, 1'b0));
    rdc(A_ST, exp_st(3'b000, 2'b00, 1'b1));
    ind[3] <= 1'b0;
    wt(4);
    ind[3] <= 1'b1;
    wt(4);
    rdc(A_ST, exp_st(3'b000, 2'b00, 1'b0));
    rdc(A_ST, exp_st(3'b000, 2'b00, 1'b1));
    rdc(A_IS, 32'h8);
    chk({31'h0, irq}, 32'h0);
    wr(A_IS, 32'hF);
    rnd = xs(rnd);
    mask = rnd[3:0];
    wr(A_IM, {28'h0, mask});
    rdc(A_IM, {28'h0, mask});
    // Each latched event: set, hold after drop, random zero-clear
    seen = 3'b000;
    for (int i = 0; i < 3; i++)
    begin
      ind[i] <= 1'b1;
      wt(4);
      seen = seen | (3'b100 >> i);
      rdc(A_ST, exp_st(seen, (i < 2) ? (2'b10 >> i) : 2'b00, 1'b1));
      ind[i] <= 1'b0;
      wt(4);
      rdc(A_ST, exp_st(seen, 2'b00, 1'b1));
      rnd = xs(rnd);
      wr(A_ST, {16'h0, rnd[15:0]});
      seen = seen & {rnd[11], rnd[10], rnd[7]};
      rdc(A_ST, exp_st(seen, 2'b00, 1'b1));
    end
    // Interrupt: masked, unmasked, cleared by ones
    rdc(A_IS, 32'h7);
    chk({31'h0, irq}, {31'h0, |mask[2:0]});
    wr(A_IM, 32'hF);
    wt(2);
    chk({31'h0, irq}, 32'h1);
    wr(A_IS, 32'h7);
    wt(2);
    rdc(A_IS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Control: lane gating, self-clearing reset, loopback
    ind[0] <= 1'b1;
    wt(4);
    ind[0] <= 1'b0;
    wt(4);
    rdc(A_ST, exp_st(seen | 3'b100, 2'b00, 1'b1));
    pstrb <= 4'h1;
    wr(A_CT, 32'h4000);
    rdc(A_CT, 32'h0);
    pstrb <= 4'hF;
    wr(A_CT, 32'hC000);
    cnt = 0;
    repeat (4)
    begin
      #1;
      cnt += (soft_rst === 1'b1) ? 1 : 0;
      @(posedge pclk);
    end
    chk(cnt, 1);
    chk({31'h0, loop_en}, 32'h1);
    rdc(A_CT, 32'h4000);
    rdc(A_ST, exp_st(3'b000, 2'b00, 1'b1));
    // Fault still present while software clears: the set wins
    ind[2] <= 1'b1;
    wt(4);
    wr(A_ST, 32'h0);
    ind[2] <= 1'b0;
    wt(4);
    rdc(A_ST, exp_st(3'b001, 2'b00, 1'b1));
    wr(A_CT, 32'h0);
    wt(1);
    chk({31'h0, loop_en}, 32'h0);
    wrap_up();
  end
endmodule

`default_nettype wire
